// >>> include/rpf_pkg.sv
package rpf_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int FILTER_US = 110;
    localparam int FILTER_CYC = FILTER_US * CLK_MHZ;
    localparam int WAKE_WAIT_MS = 50;
    localparam int WAKE_WAIT_CYC = WAKE_WAIT_MS * 1000 * CLK_MHZ;

    // ------------------------------------------------------------------
    // Timer 0 clock selection and supply threshold codes
    // ------------------------------------------------------------------
    localparam logic [3:0] SEL_RESET = 4'h0;
    localparam logic [1:0] PERIOD_100MS = 2'h0;
    localparam logic [1:0] PERIOD_5MS = 2'h1;
    localparam logic [1:0] PERIOD_1MS = 2'h2;
    localparam logic [1:0] THR_HIGH = 2'h0;
    localparam logic [1:0] THR_LOW = 2'h1;

    typedef enum logic [4:0] {
        RPF_OFF = 5'b0_0001,
        RPF_HALT = 5'b0_0010,
        RPF_RUN = 5'b0_0100,
        RPF_STOP = 5'b0_1000,
        RPF_WAKE = 5'b1_0000
    } rpf_state_t;

    typedef struct packed {
        logic forced_halt_reset;
        logic control_register_init;
        logic core_reset;
    } rpf_resets_t;

endpackage : rpf_pkg

// >>> hdl/rpf_reset_seq.sv
`timescale 1ns/1ps
// Contract
// - Plain enable reset keeps selection, waits pulse edge
// - Program runs until that pulse edge
// - Clock-stop asserts all three resets
// - Clock-stop clears timer selection to zero
// - Forced halt held while enable low
// - Enable rise restarts oscillator, release on pulse
// - Return from stop drops core and init resets at enable rise
// - Supply low stops oscillator, holds resets
// - Supply recovery releases resets, halt until pulse
// - Threshold high normally, low in clock-stop
// - Supply low initialises all core state
// - Supply low stops device regardless enable
// - Threshold back high 50 ms after wake
// - Enable with supply gives only power-on sequence
// - Enable rise after power-on causes enable reset
// - Carry-disable set by supply low, cleared read
// - Carry flag held clear while disabled
// - Enabled carry flag set each pulse edge
// - Clock-stop only acts while enable low
// - Enable input filters short pulses
module rpf_reset_seq #(
    parameter int FILTER_CYCLES = rpf_pkg::FILTER_CYC,
    parameter int WAKE_CYCLES = rpf_pkg::WAKE_WAIT_CYC
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic ENABLE_PIN,
    input wire logic SUPPLY_BELOW_HIGH,
    input wire logic SUPPLY_BELOW_LOW,
    input wire logic SET_PULSE,
    input wire logic CLOCK_STOP_INSTR,
    input wire logic CARRY_READ,
    input wire logic SEL_WRITE,
    input wire logic [3:0] SEL_WDATA,
    output logic [3:0] TIMER0_SEL,
    output logic [1:0] PERIOD_CODE,
    output logic [1:0] THRESHOLD_SEL,
    output logic SUPPLY_LOW_CLEAR,
    output logic OSC_ENABLE,
    output logic CORE_RUN,
    output rpf_pkg::rpf_resets_t RESETS,
    output logic TIMER0_CARRY_FLAG,
    output logic CARRY_DISABLE,
    output logic ENABLE_LEVEL
);

    if (FILTER_CYCLES < 1 || WAKE_CYCLES < 1) begin : g_bad_counts
        $error("rpf_reset_seq: counts must be at least one");
    end

    // ------------------------------------------------------------------
    // Input filtering and edge detection
    // ------------------------------------------------------------------
    logic [31:0] flt_cnt_reg;
    logic en_lvl_reg;
    logic en_lvl_d_reg;
    logic pulse_d_reg;
    logic [31:0] wake_cnt_reg;
    rpf_pkg::rpf_state_t state_reg, state_next;
    logic [3:0] sel_reg;
    logic carry_reg;
    logic cdis_reg;
    logic supply_clr_reg;
    logic core_rst_reg;
    logic ce_pend_reg;

    // A level change counts only once it has held for the full window.
    wire flt_diff = ENABLE_PIN != en_lvl_reg;
    wire flt_done = flt_diff && (flt_cnt_reg >= 32'(FILTER_CYCLES - 1));
    always_ff @(posedge CLK) begin
        if (SRST) begin
            flt_cnt_reg <= 32'h0000_0000;
            en_lvl_reg <= 1'b0;
            en_lvl_d_reg <= 1'b0;
            pulse_d_reg <= 1'b0;
        end else begin
            flt_cnt_reg <= (flt_diff && !flt_done) ? flt_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
            en_lvl_reg <= flt_done ? ENABLE_PIN : en_lvl_reg;
            en_lvl_d_reg <= en_lvl_reg;
            pulse_d_reg <= SET_PULSE;
        end
    end

    wire en_rise = en_lvl_reg && !en_lvl_d_reg;
    wire pulse_rise = SET_PULSE && !pulse_d_reg;

    // ------------------------------------------------------------------
    // Supply comparator selection
    // ------------------------------------------------------------------
    wire in_stop = (state_reg == rpf_pkg::RPF_STOP);
    wire in_wake = (state_reg == rpf_pkg::RPF_WAKE);
    // The low threshold lasts through the wake wait, so battery backup survives it.
    wire thr_low = in_stop || (in_wake && wake_cnt_reg < 32'(WAKE_CYCLES));
    wire supply_low = thr_low ? SUPPLY_BELOW_LOW : SUPPLY_BELOW_HIGH;
    wire stop_ok = CLOCK_STOP_INSTR && !en_lvl_reg && (state_reg == rpf_pkg::RPF_RUN);

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            rpf_pkg::RPF_OFF: begin
                if (!supply_low) begin
                    state_next = rpf_pkg::RPF_HALT;
                end
            end
            rpf_pkg::RPF_HALT: begin
                if (pulse_rise) begin
                    state_next = rpf_pkg::RPF_RUN;
                end
            end
            rpf_pkg::RPF_RUN: begin
                if (stop_ok) begin
                    state_next = rpf_pkg::RPF_STOP;
                end
            end
            rpf_pkg::RPF_STOP: begin
                if (en_rise) begin
                    state_next = rpf_pkg::RPF_WAKE;
                end
            end
            rpf_pkg::RPF_WAKE: begin
                if (pulse_rise) begin
                    state_next = rpf_pkg::RPF_RUN;
                end
            end
            default: state_next = rpf_pkg::RPF_OFF;
        endcase
        if (supply_low) begin
            state_next = rpf_pkg::RPF_OFF;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            state_reg <= rpf_pkg::RPF_OFF;
            wake_cnt_reg <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            if (in_wake && wake_cnt_reg < 32'(WAKE_CYCLES)) begin
                wake_cnt_reg <= wake_cnt_reg + 32'h0000_0001;
            end else if (!in_wake) begin
                wake_cnt_reg <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------------
    // Enable-pin reset and control registers
    // ------------------------------------------------------------------
    wire is_run = (state_reg == rpf_pkg::RPF_RUN);
    wire ce_fire = is_run && (ce_pend_reg || en_rise) && pulse_rise;
    wire sel_clear = supply_clr_reg || stop_ok;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            ce_pend_reg <= 1'b0;
            sel_reg <= rpf_pkg::SEL_RESET;
            core_rst_reg <= 1'b1;
            supply_clr_reg <= 1'b1;
        end else begin
            supply_clr_reg <= supply_low;
            // Pending is dropped unless the core is running, so the power-on path wins.
            ce_pend_reg <= is_run && !ce_fire && (ce_pend_reg || en_rise);
            if (sel_clear) begin
                sel_reg <= rpf_pkg::SEL_RESET;
            end else if (SEL_WRITE && is_run) begin
                sel_reg <= SEL_WDATA;
            end
            core_rst_reg <= ce_fire || state_next == rpf_pkg::RPF_OFF
                || state_next == rpf_pkg::RPF_STOP;
        end
    end

    // ------------------------------------------------------------------
    // Carry-disable and carry flag
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SRST) begin
            cdis_reg <= 1'b1;
            carry_reg <= 1'b0;
        end else begin
            if (supply_low) begin
                cdis_reg <= 1'b1;
            end else if (CARRY_READ) begin
                cdis_reg <= 1'b0;
            end
            if (supply_low || cdis_reg) begin
                carry_reg <= 1'b0;
            end else if (pulse_rise) begin
                carry_reg <= 1'b1;
            end else if (CARRY_READ) begin
                carry_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    wire halt_hold = (state_reg != rpf_pkg::RPF_RUN);
    wire resets_on = (state_reg == rpf_pkg::RPF_OFF) || in_stop;
    assign TIMER0_SEL = sel_reg;
    assign PERIOD_CODE = (sel_reg == rpf_pkg::SEL_RESET) ? rpf_pkg::PERIOD_100MS
        : (sel_reg[0] ? rpf_pkg::PERIOD_1MS : rpf_pkg::PERIOD_5MS);
    assign THRESHOLD_SEL = thr_low ? rpf_pkg::THR_LOW : rpf_pkg::THR_HIGH;
    assign SUPPLY_LOW_CLEAR = supply_clr_reg;
    assign OSC_ENABLE = !resets_on;
    assign CORE_RUN = !halt_hold;
    assign RESETS.forced_halt_reset = halt_hold;
    assign RESETS.control_register_init = resets_on;
    assign RESETS.core_reset = core_rst_reg;
    assign TIMER0_CARRY_FLAG = carry_reg;
    assign CARRY_DISABLE = cdis_reg;
    assign ENABLE_LEVEL = en_lvl_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_stop_resets;
        @(posedge CLK) disable iff (SRST) stop_ok && !supply_low |=> RESETS.core_reset
            && state_reg == rpf_pkg::RPF_STOP && sel_reg == rpf_pkg::SEL_RESET;
    endproperty
    a_stop_resets: assert property (p_stop_resets) else $error("stop reset missing");
    property p_stop_nop;
        @(posedge CLK) disable iff (SRST) CLOCK_STOP_INSTR && en_lvl_reg && is_run
            && !supply_low && !ce_fire |=> is_run;
    endproperty
    a_stop_nop: assert property (p_stop_nop) else $error("stop with enable high");
    property p_off;
        @(posedge CLK) disable iff (SRST) supply_low |=> state_reg == rpf_pkg::RPF_OFF
            && !OSC_ENABLE && RESETS.forced_halt_reset;
    endproperty
    a_off: assert property (p_off) else $error("supply low not honoured");
    property p_cdis;
        @(posedge CLK) disable iff (SRST) cdis_reg |=> !carry_reg;
    endproperty
    a_cdis: assert property (p_cdis) else $error("carry set while disabled");
    property p_carry;
        @(posedge CLK) disable iff (SRST) !cdis_reg && !supply_low && pulse_rise |=> carry_reg;
    endproperty
    a_carry: assert property (p_carry) else $error("carry not set");
    property p_cdis_set;
        @(posedge CLK) disable iff (SRST) supply_low |=> cdis_reg;
    endproperty
    a_cdis_set: assert property (p_cdis_set) else $error("disable not set");
    property p_halt_rel;
        @(posedge CLK) disable iff (SRST) state_reg == rpf_pkg::RPF_HALT && pulse_rise
            && !supply_low |=> is_run ##0 CORE_RUN;
    endproperty
    a_halt_rel: assert property (p_halt_rel) else $error("halt not released");
    property p_ce;
        @(posedge CLK) disable iff (SRST) ce_fire && !supply_low && !stop_ok
            |=> core_rst_reg && is_run;
    endproperty
    a_ce: assert property (p_ce) else $error("enable reset missing");
    property p_wake_thr;
        @(posedge CLK) disable iff (SRST) in_wake && wake_cnt_reg == 32'(WAKE_CYCLES)
            |-> !thr_low;
    endproperty
    a_wake_thr: assert property (p_wake_thr) else $error("threshold not raised");
    c_stop: cover property (@(posedge CLK) disable iff (SRST) stop_ok);
    c_wake: cover property (@(posedge CLK) disable iff (SRST) in_wake ##1 is_run);
    c_ce: cover property (@(posedge CLK) disable iff (SRST) ce_fire);

    // ------------------------------------------------------------------
    // Sequence and register checks
    // ------------------------------------------------------------------
    // A pending enable reset must never disturb the selection, or the wait would shift.
    property p_filter;
        @(posedge CLK) disable iff (SRST) !flt_done |=> $stable(ENABLE_LEVEL);
    endproperty
    a_filter: assert property (p_filter) else $error("enable level moved early");
    property p_stop_hold;
        @(posedge CLK) disable iff (SRST) in_stop && !en_lvl_reg
            |=> RESETS.forced_halt_reset && !OSC_ENABLE;
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stop state left early");
    property p_wake_hold;
        @(posedge CLK) disable iff (SRST) in_wake && !pulse_rise |=> !CORE_RUN;
    endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("wake released early");
    property p_wake_rel;
        @(posedge CLK) disable iff (SRST) in_wake && pulse_rise && !supply_low
            |=> CORE_RUN && !RESETS.forced_halt_reset;
    endproperty
    a_wake_rel: assert property (p_wake_rel) else $error("wake not released");
    property p_sel_keep;
        @(posedge CLK) disable iff (SRST) is_run && !stop_ok && !SEL_WRITE
            |=> $stable(TIMER0_SEL);
    endproperty
    a_sel_keep: assert property (p_sel_keep) else $error("selection changed");
    property p_ce_wait;
        @(posedge CLK) disable iff (SRST) is_run && en_rise && !pulse_rise && !supply_low
            |=> CORE_RUN && !RESETS.core_reset;
    endproperty
    a_ce_wait: assert property (p_ce_wait) else $error("enable reset too early");
    property p_thr_stop;
        @(posedge CLK) disable iff (SRST) in_stop |-> THRESHOLD_SEL == rpf_pkg::THR_LOW;
    endproperty
    a_thr_stop: assert property (p_thr_stop) else $error("threshold not low in stop");
    c_halt_rel: cover property (@(posedge CLK) disable iff (SRST)
        state_reg == rpf_pkg::RPF_HALT ##1 is_run);
    c_off: cover property (@(posedge CLK) disable iff (SRST) supply_low ##1 !OSC_ENABLE);

endmodule : rpf_reset_seq

// >>> dv/rpf_partner.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Far side: enable pin driver and supply monitor.
// ----------------------------------------------------------------------
module rpf_partner #(
    parameter logic [15:0] HIGH_MV = 16'h0dac,
    parameter logic [15:0] LOW_MV = 16'h0898
) (
    input wire logic clk,
    input wire logic en_req,
    input wire logic [15:0] supply_mv,
    output logic enable_pin,
    output logic below_high,
    output logic below_low
);
    // The comparators are ideal, so every threshold crossing lands on a known edge.
    always @(posedge clk) begin
        enable_pin <= en_req;
        below_high <= supply_mv < HIGH_MV;
        below_low <= supply_mv < LOW_MV;
    end
endmodule : rpf_partner

// >>> dv/reset_and_power_fail_detect_tb.sv
`timescale 1ns/1ps
module reset_and_power_fail_detect_tb;
    logic clk = 1'h0, srst = 1'h1, en_req = 1'h0, set_pulse = 1'h0, stop_instr = 1'h0;
    logic carry_read = 1'h0, sel_write = 1'h0;
    logic [3:0] sel_wdata = 4'h0;
    logic [15:0] supply_mv = 16'h1388;
    logic enable_pin, below_high, below_low, supply_low_clear, osc_enable, core_run;
    logic carry_flag, carry_disable, enable_level;
    logic [3:0] timer0_sel;
    logic [1:0] period_code, threshold_sel;
    rpf_pkg::rpf_resets_t resets;
    int miscompares = 0;
    int compares = 0;
    int core_pulses = 0;
    // ------------------------------------------------------------------
    // Clock, far side and block
    // ------------------------------------------------------------------
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (resets.core_reset === 1'h1) begin
            core_pulses <= core_pulses + 1;
        end
    end
    rpf_partner PARTNER (.clk(clk), .en_req(en_req), .supply_mv(supply_mv),
        .enable_pin(enable_pin), .below_high(below_high), .below_low(below_low));
    rpf_reset_seq #(.FILTER_CYCLES(4), .WAKE_CYCLES(20)) DUT (.CLK(clk), .SRST(srst),
        .ENABLE_PIN(enable_pin), .SUPPLY_BELOW_HIGH(below_high),
        .SUPPLY_BELOW_LOW(below_low), .SET_PULSE(set_pulse),
        .CLOCK_STOP_INSTR(stop_instr), .CARRY_READ(carry_read), .SEL_WRITE(sel_write),
        .SEL_WDATA(sel_wdata), .TIMER0_SEL(timer0_sel), .PERIOD_CODE(period_code),
        .THRESHOLD_SEL(threshold_sel), .SUPPLY_LOW_CLEAR(supply_low_clear),
        .OSC_ENABLE(osc_enable), .CORE_RUN(core_run), .RESETS(resets),
        .TIMER0_CARRY_FLAG(carry_flag), .CARRY_DISABLE(carry_disable),
        .ENABLE_LEVEL(enable_level));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step
    task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // Strobes last one cycle: 0 timer pulse, 1 clock-stop, 2 carry read.
    task automatic pulse(input int which);
        @(posedge clk);
        case (which)
            0: set_pulse <= 1'h1;
            1: stop_instr <= 1'h1;
            default: carry_read <= 1'h1;
        endcase
        @(posedge clk);
        set_pulse <= 1'h0;
        stop_instr <= 1'h0;
        carry_read <= 1'h0;
        step(3);
    endtask : pulse
    task automatic set_en(input logic v);
        @(posedge clk);
        en_req <= v;
        step(12);
    endtask : set_en
    task automatic set_supply(input logic [15:0] mv);
        @(posedge clk);
        supply_mv <= mv;
        step(4);
    endtask : set_supply
    task automatic set_sel(input logic [3:0] v);
        @(posedge clk);
        sel_write <= 1'h1;
        sel_wdata <= v;
        @(posedge clk);
        sel_write <= 1'h0;
        step(2);
    endtask : set_sel
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_power_on;
        chk(osc_enable, 4'h1, "osc after supply ok");
        chk(core_run, 4'h0, "halt before pulse");
        chk(timer0_sel, rpf_pkg::SEL_RESET, "sel init");
        chk(period_code, rpf_pkg::PERIOD_100MS, "period init");
        chk(threshold_sel, rpf_pkg::THR_HIGH, "threshold run");
        pulse(0);
        chk(core_run, 4'h1, "run after pulse");
        chk(carry_disable, 4'h1, "disable after power on");
        chk(carry_flag, 4'h0, "carry held clear");
        pulse(2);
        chk(carry_disable, 4'h0, "disable cleared by read");
        pulse(0);
        chk(carry_flag, 4'h1, "carry set by pulse");
        pulse(2);
        chk(carry_flag, 4'h0, "carry cleared by read");
    endtask : t_power_on
    task automatic t_enable_reset;
        int base;
        set_sel(4'h1);
        chk(period_code, rpf_pkg::PERIOD_1MS, "selection decode");
        base = core_pulses;
        set_en(1'h1);
        chk(enable_level, 4'h1, "filtered level");
        chk(core_run, 4'h1, "runs while waiting");
        chk(4'(core_pulses - base), 4'h0, "no reset before pulse");
        pulse(0);
        chk(4'(core_pulses - base), 4'h1, "one core reset at pulse");
        chk(timer0_sel, 4'h1, "selection kept");
        @(posedge clk);
        en_req <= 1'h0;
        repeat (2) @(posedge clk);
        en_req <= 1'h1;
        step(8);
        chk(enable_level, 4'h1, "short low ignored");
        pulse(0);
        chk(4'(core_pulses - base), 4'h1, "no reset from glitch");
        set_sel(4'h2);
        chk(period_code, rpf_pkg::PERIOD_5MS, "selection decode 5 ms");
    endtask : t_enable_reset
    task automatic t_clock_stop;
        pulse(1);
        chk(core_run, 4'h1, "stop ignored with enable high");
        set_en(1'h0);
        pulse(1);
        chk(resets, 4'h7, "all resets on stop");
        chk(timer0_sel, 4'h0, "selection cleared");
        chk(osc_enable, 4'h0, "clock stopped");
        chk(threshold_sel, rpf_pkg::THR_LOW, "low threshold in stop");
        set_supply(16'h09c4);
        chk(supply_low_clear, 4'h0, "backup supply accepted");
        pulse(0);
        chk(core_run, 4'h0, "pulse cannot release stop");
        set_en(1'h1);
        chk(osc_enable, 4'h1, "oscillator restarts");
        chk(threshold_sel, rpf_pkg::THR_LOW, "threshold low during wake");
        set_supply(16'h1388);
        step(20);
        chk(threshold_sel, rpf_pkg::THR_HIGH, "threshold back high");
        chk(supply_low_clear, 4'h0, "no clear after restore");
        pulse(0);
        chk(core_run, 4'h1, "run after wake pulse");
    endtask : t_clock_stop
    task automatic t_supply_loss;
        int base;
        set_supply(16'h0bb8);
        chk(supply_low_clear, 4'h1, "clear on supply low");
        chk(osc_enable, 4'h0, "stopped despite enable high");
        chk(resets, 4'h7, "resets held");
        chk(carry_disable, 4'h1, "disable set by clear");
        set_en(1'h0);
        set_supply(16'h1388);
        chk(osc_enable, 4'h1, "oscillator after recovery");
        set_sel(4'h1);
        chk(timer0_sel, 4'h0, "write refused in halt");
        set_en(1'h1);
        pulse(0);
        chk(core_run, 4'h1, "power-on sequence only");
        base = core_pulses;
        pulse(0);
        chk(4'(core_pulses - base), 4'h0, "halt enable edge dropped");
        chk(carry_flag, 4'h0, "carry still disabled");
    endtask : t_supply_loss
    // ------------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------------
    task automatic summarize;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'h0;
        step(4);
        t_power_on();
        t_enable_reset();
        t_clock_stop();
        t_supply_loss();
        summarize();
    end
    // The scenarios need well under 600 cycles; the margin covers slow answers.
    initial begin
        #20000;
        miscompares++;
        $display("BAD %0t watchdog expired", $time);
        summarize();
    end
endmodule : reset_and_power_fail_detect_tb
